//--- rtl/cer_app_end.sv
// Application end: tracks requests and strobes completion errors.
// Assumes a software master on the plain register port, same clock
// as the core, and a completion transmitter with valid/ready.
`timescale 1ns/1ps
// Summary of operation
// - Each error is a one-cycle strobe
// - Simultaneous errors on separate bits all logged
// - Core sets status bits and sends message
// - Correctable timeout: bit zero, advisory message
// - Uncorrectable timeout: bit one, non-advisory message
// - Non-posted abort: completion first, then bit two
// - Bit two for posted or non-posted
// - Unmatched completion strobes bit three
// - Posted unsupported request strobes bit four
// - Non-posted unsupported: completion, then bit five
// - Application builds every completion itself
// - Core detects three errors by itself
// - Bit six with error logs first header
// - Header dwords written before bit six
module cer_app_end
	import cer_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [RA_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	// Request tracking
	input wire logic np_req_sent,
	input wire logic cpl_rx,
	// Completion transmitter
	output logic cpl_tx_valid,
	output logic [2:0] cpl_tx_status,
	input wire logic cpl_tx_ready,
	// Sideband
	cer_if.app sb
);
	localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYCLES - 1);

	typedef enum logic [1:0] {ST_IDLE, ST_CPL, ST_HDR, ST_STROBE} cer_st_e;

	cer_st_e st;
	logic ctrl_cor;
	logic [1:0] cmd_kind;
	logic cmd_hdr;
	logic [31:0] hdr_word [HDR_WORDS];
	logic [1:0] hdr_cnt;
	logic outstanding;
	logic [CNT_W-1:0] to_cnt;
	logic timeout_hit;
	logic unexp_hit;
	logic cmd_go;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_en;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	logic [ERR_W-1:0] next_strobe;
	logic [31:0] next_rdata;

	// Register write decode
	assign cmd_go = reg_wr && reg_addr == REG_CMD && st == ST_IDLE;
	assign irq_clr = (reg_wr && reg_addr == REG_IRQ_CLR) ?
		reg_wdata[IRQ_W-1:0] : '0;

	// Control and interrupt enable
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_cor <= CTRL_RST;
			irq_en <= IRQ_EN_RST;
		end else if (reg_wr) begin
			if (reg_addr == REG_CTRL) begin
				ctrl_cor <= reg_wdata[CTRL_COR];
			end
			if (reg_addr == REG_IRQ_EN) begin
				irq_en <= reg_wdata[IRQ_W-1:0];
			end
		end
	end

	// Header words held by software, index from the offset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < HDR_WORDS; i++) begin
				hdr_word[i] <= '0;
			end
		end else if (reg_wr && reg_addr >= REG_HDR0 && reg_addr <= REG_HDR3) begin
			hdr_word[reg_addr[3:2] - REG_HDR0[3:2]] <= reg_wdata;
		end
	end

	// Outstanding non-posted request and its timeout
	assign timeout_hit = outstanding && to_cnt == CNT_LAST;
	assign unexp_hit = cpl_rx && !outstanding;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			outstanding <= 1'b0;
			to_cnt <= '0;
		end else if (np_req_sent) begin
			outstanding <= 1'b1;
			to_cnt <= '0;
		end else if (cpl_rx || timeout_hit) begin
			outstanding <= 1'b0;
			to_cnt <= '0;
		end else if (outstanding) begin
			to_cnt <= to_cnt + 1'b1;
		end
	end

	// Command sequencer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= ST_IDLE;
			cmd_kind <= KIND_ABORT_P;
			cmd_hdr <= 1'b0;
			hdr_cnt <= '0;
		end else begin
			unique case (st)
				ST_IDLE: begin
					if (cmd_go) begin
						cmd_kind <= reg_wdata[1:0];
						cmd_hdr <= reg_wdata[CMD_HDR];
						hdr_cnt <= '0;
						if (reg_wdata[1:0] == KIND_ABORT_NP ||
							reg_wdata[1:0] == KIND_UNSUP_NP) begin
							st <= ST_CPL;
						end else if (reg_wdata[CMD_HDR]) begin
							st <= ST_HDR;
						end else begin
							st <= ST_STROBE;
						end
					end
				end
				ST_CPL: begin
					if (cpl_tx_valid && cpl_tx_ready) begin
						st <= cmd_hdr ? ST_HDR : ST_STROBE;
					end
				end
				ST_HDR: begin
					hdr_cnt <= hdr_cnt + 1'b1;
					if (hdr_cnt == 2'(HDR_WORDS - 1)) begin
						st <= ST_STROBE;
					end
				end
				ST_STROBE: begin
					st <= ST_IDLE;
				end
			endcase
		end
	end

	// Completion built here with its status code
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cpl_tx_valid <= 1'b0;
			cpl_tx_status <= COMPLETER_ABORT_STATUS;
		end else if (cmd_go && (reg_wdata[1:0] == KIND_ABORT_NP ||
			reg_wdata[1:0] == KIND_UNSUP_NP)) begin
			cpl_tx_valid <= 1'b1;
			cpl_tx_status <= reg_wdata[1:0] == KIND_ABORT_NP ?
				COMPLETER_ABORT_STATUS :
				UNSUPPORTED_REQUEST_STATUS;
		end else if (cpl_tx_ready) begin
			cpl_tx_valid <= 1'b0;
		end
	end

	// Header dwords to the core, most significant first
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sb.hdr_wr <= 1'b0;
			sb.hdr_addr <= HDR_ADDR0;
			sb.hdr_data <= '0;
		end else begin
			sb.hdr_wr <= st == ST_HDR;
			sb.hdr_addr <= HDR_ADDR0 + {8'h00, hdr_cnt, 2'h0};
			sb.hdr_data <= hdr_word[hdr_cnt];
		end
	end

	// All error causes merge into one strobe vector
	always_comb begin
		next_strobe = '0;
		if (timeout_hit) begin
			next_strobe[ERR_TO_COR] = ctrl_cor;
			next_strobe[ERR_TO_UNC] = !ctrl_cor;
		end
		next_strobe[ERR_UNEXP] = unexp_hit;
		if (st == ST_STROBE) begin
			next_strobe[ERR_ABORT] = cmd_kind == KIND_ABORT_P ||
				cmd_kind == KIND_ABORT_NP;
			next_strobe[ERR_UNSUP_P] = cmd_kind == KIND_UNSUP_P;
			next_strobe[ERR_UNSUP_NP] = cmd_kind == KIND_UNSUP_NP;
			next_strobe[ERR_HDR] = cmd_hdr;
		end
	end

	// Strobes last exactly one cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sb.err_strobe <= '0;
		end else begin
			sb.err_strobe <= next_strobe;
		end
	end

	// Sticky interrupt status, a new event beats a clear
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_TIMEOUT] = timeout_hit;
		irq_set[IRQ_UNEXP] = unexp_hit;
		irq_set[IRQ_DONE] = st == ST_STROBE;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_stat <= '0;
			irq <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
			irq <= |(((irq_stat & ~irq_clr) | irq_set) & irq_en);
		end
	end

	// Read mux, data one cycle after the strobe
	always_comb begin
		next_rdata = '0;
		unique case (reg_addr)
			REG_CTRL: next_rdata[CTRL_COR] = ctrl_cor;
			REG_HDR0: next_rdata = hdr_word[0];
			REG_HDR0 + 8'h04: next_rdata = hdr_word[1];
			REG_HDR0 + 8'h08: next_rdata = hdr_word[2];
			REG_HDR3: next_rdata = hdr_word[3];
			REG_STATUS: next_rdata[1:0] = {outstanding, st != ST_IDLE};
			REG_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
			REG_IRQ_EN: next_rdata[IRQ_W-1:0] = irq_en;
			default: next_rdata = '0;
		endcase
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : '0;
		end
	end
endmodule : cer_app_end

//--- rtl/cer_core_end.sv
// Core end: takes error strobes, keeps status bits, sends messages.
// Assumes strobes come from logic on the same clock, one cycle each.
`timescale 1ns/1ps
module cer_core_end
	import cer_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Sideband
	cer_if.core sb,
	// Errors found by the transaction layer itself
	input wire logic tl_unexp_cpl,
	input wire logic tl_unsup_p,
	input wire logic tl_unsup_np,
	// Configuration status
	input wire logic [CLS_W-1:0] status_clear,
	output logic [CLS_W-1:0] err_status,
	// Error messages
	output logic msg_valid,
	output logic [1:0] msg_type,
	// Header log
	input wire logic hdr_log_release,
	output logic hdr_log_valid,
	output logic [127:0] hdr_log
);
	logic [CLS_W-1:0] ev;
	logic [CLS_W-1:0] pend;
	logic [CLS_W-1:0] grant;
	logic [31:0] logged_request_header [HDR_WORDS];
	logic hdr_in_range;
	logic [1:0] hdr_idx;
	logic hdr_hit;

	// Strobe bits zero to five and every internal detection, all in one cycle
	always_comb begin
		ev = sb.err_strobe[CLS_W-1:0];
		ev[ERR_UNEXP] = sb.err_strobe[ERR_UNEXP] | tl_unexp_cpl;
		ev[ERR_UNSUP_P] = sb.err_strobe[ERR_UNSUP_P] | tl_unsup_p;
		ev[ERR_UNSUP_NP] = sb.err_strobe[ERR_UNSUP_NP] | tl_unsup_np;
	end

	// Sticky status bits, a new error beats a clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			err_status <= '0;
		end else begin
			err_status <= (err_status & ~status_clear) | ev;
		end
	end

	// Pending messages, one per class
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pend <= '0;
		end else begin
			pend <= (pend & ~grant) | ev;
		end
	end

	cer_pick i_cer_pick (
		.pend(pend),
		.grant(grant)
	);

	// Advisory for correctable timeout, non-advisory otherwise
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			msg_valid <= 1'b0;
			msg_type <= MSG_COR;
		end else begin
			msg_valid <= |pend;
			msg_type <= grant[ERR_TO_COR] ? MSG_COR : MSG_NONFATAL;
		end
	end

	// Header staging words written by the application
	assign hdr_in_range = sb.hdr_addr >= HDR_ADDR0 &&
		sb.hdr_addr <= HDR_ADDR3 && sb.hdr_addr[1:0] == 2'h0;
	assign hdr_idx = 2'(sb.hdr_addr[11:2] - HDR_ADDR0[11:2]);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < HDR_WORDS; i++) begin
				logged_request_header[i] <= '0;
			end
		end else if (sb.hdr_wr && hdr_in_range) begin
			logged_request_header[hdr_idx] <= sb.hdr_data;
		end
	end

	// Log the header only for the first error strobed with bit six since release
	assign hdr_hit = sb.err_strobe[ERR_HDR] &&
		|sb.err_strobe[ERR_UNSUP_NP:ERR_ABORT];
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hdr_log_valid <= 1'b0;
			hdr_log <= '0;
		end else if (hdr_hit && !hdr_log_valid) begin
			hdr_log_valid <= 1'b1;
			hdr_log <= {logged_request_header[0], logged_request_header[1],
				logged_request_header[2], logged_request_header[3]};
		end else if (hdr_log_release) begin
			hdr_log_valid <= 1'b0;
		end
	end
endmodule : cer_core_end

//--- rtl/cer_if.sv
// Sideband between application logic and the endpoint core.
// Assumes both ends sit on the same clock; no clock lives here.
`timescale 1ns/1ps
interface cer_if;
	logic [6:0] err_strobe;
	logic hdr_wr;
	logic [11:0] hdr_addr;
	logic [31:0] hdr_data;

	modport core (
		input err_strobe,
		input hdr_wr,
		input hdr_addr,
		input hdr_data
	);
	modport app (
		output err_strobe,
		output hdr_wr,
		output hdr_addr,
		output hdr_data
	);
endinterface : cer_if

//--- rtl/cer_pick.sv
// Lowest-index picker over pending message classes.
// Assumes the caller registers whatever depends on the grant.
`timescale 1ns/1ps
module cer_pick
	import cer_pkg::*;
(
	// Pending and grant
	input wire logic [CLS_W-1:0] pend,
	output logic [CLS_W-1:0] grant
);
	logic [CLS_W:0] lower;

	// One grant per cycle, lowest class first
	assign lower[0] = 1'b0;
	for (genvar i = 0; i < CLS_W; i++) begin : g_bit
		assign lower[i+1] = lower[i] | pend[i];
		assign grant[i] = pend[i] & ~lower[i];
	end
endmodule : cer_pick

//--- rtl/cer_pkg.sv
// Constants shared by both ends of the completion error sideband.
// Assumes one 200 MHz clock shared by the application and the core.
package cer_pkg;
	// Error strobe bit positions
	localparam int ERR_W = 7;
	localparam int ERR_TO_COR = 0;
	localparam int ERR_TO_UNC = 1;
	localparam int ERR_ABORT = 2;
	localparam int ERR_UNEXP = 3;
	localparam int ERR_UNSUP_P = 4;
	localparam int ERR_UNSUP_NP = 5;
	localparam int ERR_HDR = 6;
	localparam int CLS_W = 6;

	// Completion timeout
	localparam int TIMEOUT_MS = 50;
	localparam int CLK_MHZ = 200;
	localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_MHZ * 1000;

	// Header log staging words, most significant dword first
	localparam logic [11:0] HDR_ADDR0 = 12'h81c;
	localparam logic [11:0] HDR_ADDR3 = 12'h828;
	localparam int HDR_WORDS = 4;

	// Completion status codes
	localparam logic [2:0] UNSUPPORTED_REQUEST_STATUS = 3'h1;
	localparam logic [2:0] COMPLETER_ABORT_STATUS = 3'h4;

	// Error message types toward the root complex
	localparam logic [1:0] MSG_COR = 2'h0;
	localparam logic [1:0] MSG_NONFATAL = 2'h1;

	// Application control register map
	localparam int RA_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_HDR0 = 8'h08;
	localparam logic [7:0] REG_HDR3 = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam logic [7:0] REG_IRQ_STAT = 8'h1c;
	localparam logic [7:0] REG_IRQ_CLR = 8'h20;
	localparam logic [7:0] REG_IRQ_EN = 8'h24;

	// Fields
	localparam int CTRL_COR = 0;
	localparam int CMD_HDR = 2;
	localparam logic [1:0] KIND_ABORT_P = 2'h0;
	localparam logic [1:0] KIND_ABORT_NP = 2'h1;
	localparam logic [1:0] KIND_UNSUP_P = 2'h2;
	localparam logic [1:0] KIND_UNSUP_NP = 2'h3;
	localparam int IRQ_W = 3;
	localparam int IRQ_TIMEOUT = 0;
	localparam int IRQ_UNEXP = 1;
	localparam int IRQ_DONE = 2;

	// Reset values
	localparam logic CTRL_RST = 1'h0;
	localparam logic [2:0] IRQ_EN_RST = 3'h0;
endpackage : cer_pkg

//--- verification/cer_monitor.sv
// Assertions on the completion error sideband between the two ends.
// Assumes one clock; the bench wires the interface signals in here.
`timescale 1ns/1ps
module cer_monitor
	import cer_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Sideband
	input wire logic [6:0] err_strobe,
	input wire logic hdr_wr,
	input wire logic [11:0] hdr_addr
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// Remaining header words after the first
	sequence hdr_tail_s;
		hdr_wr && hdr_addr == HDR_ADDR0 + 12'h4 ##1
		hdr_wr && hdr_addr == HDR_ADDR0 + 12'h8 ##1
		hdr_wr && hdr_addr == HDR_ADDR3;
	endsequence

	// First header word opens a burst
	sequence hdr_head_s;
		hdr_wr && hdr_addr == HDR_ADDR0;
	endsequence

	strobe_one_cycle_a: assert property (
		(err_strobe & $past(err_strobe)) == 7'h0)
		else $error("error strobe held longer than one cycle");
	hdr_with_err_a: assert property (
		err_strobe[ERR_HDR] |-> |err_strobe[ERR_UNSUP_NP:ERR_ABORT])
		else $error("header strobe without its error bit");
	hdr_after_words_a: assert property (
		err_strobe[ERR_HDR] |-> $past(hdr_wr) && $past(hdr_addr) == HDR_ADDR3)
		else $error("header strobe not right after last word");
	hdr_burst_order_a: assert property (
		hdr_head_s |=> hdr_tail_s ##1 err_strobe[ERR_HDR])
		else $error("header words out of order");
	burst_start_a: assert property (
		$rose(hdr_wr) |-> hdr_addr == HDR_ADDR0)
		else $error("header burst starts at wrong word");
	burst_length_a: assert property (
		hdr_wr [*4] |=> !hdr_wr)
		else $error("header burst longer than four words");
	timeout_excl_a: assert property (
		!(err_strobe[ERR_TO_COR] && err_strobe[ERR_TO_UNC]))
		else $error("both timeout classes at once");
	cmd_single_a: assert property (
		err_strobe[ERR_ABORT] |->
		!err_strobe[ERR_UNSUP_P] && !err_strobe[ERR_UNSUP_NP])
		else $error("two command errors in one strobe");
endmodule : cer_monitor

//--- verification/test_completion_error_report_sideband.sv
// Bench joining both ends, plus a second core driven directly.
// Assumes the package, interface and both ends compile first.
`timescale 1ns/1ps
module test_completion_error_report_sideband import cer_pkg::*;;
	logic clk, rstn = 1'b0, wr = 1'b0, rd = 1'b0, np = 1'b0, crx = 1'b0;
	logic rdy = 1'b0, tu = 1'b0, tp = 1'b0, tn = 1'b0, rel = 1'b0;
	logic [7:0] ra = 8'h0;
	logic [31:0] wd = 32'h0, rdata;
	logic [31:0] hw [4];
	logic [5:0] sclr = 6'h0, st, st2;
	logic [2:0] cts;
	logic [1:0] mt, mt2, lt;
	logic [127:0] hl, hl2;
	logic irq, ctv, mv, mv2, hv, hv2;
	int n_mismatch = 0, checks = 0, nm = 0, nm2 = 0, n0, k;
	int bt [4] = '{ERR_ABORT, ERR_ABORT, ERR_UNSUP_P, ERR_UNSUP_NP};
	cer_if sb_a();
	cer_if sb_b();
	cer_app_end #(.TIMEOUT_CYCLES(20)) i_cer_app_end (.clk(clk), .rstn(rstn),
		.reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdata), .irq(irq), .np_req_sent(np), .cpl_rx(crx),
		.cpl_tx_valid(ctv), .cpl_tx_status(cts), .cpl_tx_ready(rdy), .sb(sb_a));
	cer_core_end i_cer_core_end (.clk(clk), .rstn(rstn), .sb(sb_a),
		.tl_unexp_cpl(tu), .tl_unsup_p(tp), .tl_unsup_np(tn),
		.status_clear(sclr),
		.err_status(st), .msg_valid(mv), .msg_type(mt),
		.hdr_log_release(rel), .hdr_log_valid(hv), .hdr_log(hl));
	cer_core_end i_cer_core_end_b (.clk(clk), .rstn(rstn), .sb(sb_b),
		.tl_unexp_cpl(1'b0), .tl_unsup_p(1'b0), .tl_unsup_np(1'b0),
		.status_clear(sclr), .err_status(st2), .msg_valid(mv2),
		.msg_type(mt2), .hdr_log_release(rel), .hdr_log_valid(hv2),
		.hdr_log(hl2));
	cer_monitor i_cer_monitor (.clk(clk), .rstn(rstn),
		.err_strobe(sb_a.err_strobe), .hdr_wr(sb_a.hdr_wr),
		.hdr_addr(sb_a.hdr_addr));

	// Clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Count error messages of both cores
	always @(posedge clk) begin
		if (mv === 1'b1) begin
			nm++;
			lt = mt;
		end
		if (mv2 === 1'b1)
			nm2++;
	end

	task results;
		if (n_mismatch == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	task chk(input logic [127:0] g, input logic [127:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg

	task rreg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		ra <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask : rreg

	// Bounded wait for one core status bit
	task wst(input int b);
		int i;
		for (i = 0; i < 200 && st[b] !== 1'b1; i++)
			@(posedge clk);
		chk(st[b], 1'b1);
	endtask : wst

	task clr;
		@(posedge clk);
		sclr <= 6'h3f;
		@(posedge clk);
		sclr <= 6'h00;
		@(posedge clk);
	endtask : clr

	// Pulse request or completion inputs
	task pul(input logic a, input logic c);
		@(posedge clk);
		np <= a;
		crx <= c;
		@(posedge clk);
		np <= 1'b0;
		crx <= 1'b0;
	endtask : pul

	initial begin
		sb_b.err_strobe = 7'h0;
		sb_b.hdr_wr = 1'b0;
		sb_b.hdr_addr = 12'h0;
		sb_b.hdr_data = 32'h0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rreg(REG_CTRL, 32'h0);
		rreg(REG_IRQ_EN, 32'h0);
		rreg(8'h40, 32'h0);
		// Every command kind, completion held back for a while
		for (k = 0; k < 4; k++) begin
			n0 = nm;
			wreg(REG_CMD, 32'(k));
			repeat (4) @(posedge clk);
			chk(ctv, k % 2);
			if (k % 2 == 1) begin
				chk(cts, k < 2 ? COMPLETER_ABORT_STATUS :
					UNSUPPORTED_REQUEST_STATUS);
				chk(st, 6'h0);
				rreg(REG_STATUS, 32'h1);
			end
			rdy <= 1'b1;
			wst(bt[k]);
			repeat (4) @(posedge clk);
			chk(nm - n0, 1);
			chk(lt, MSG_NONFATAL);
			rdy <= 1'b0;
			clr;
		end
		// Header log, then a second header ignored until release
		for (k = 0; k < 4; k++) begin
			hw[k] = 32'hc0de0000 + 32'(k);
			wreg(REG_HDR0 + 8'(4 * k), hw[k]);
		end
		wreg(REG_CMD, 32'h6);
		wst(ERR_UNSUP_P);
		chk(hv, 1'b1);
		chk(hl, {hw[0], hw[1], hw[2], hw[3]});
		wreg(REG_HDR0, 32'h0);
		wreg(REG_CMD, 32'h6);
		repeat (12) @(posedge clk);
		chk(hl, {hw[0], hw[1], hw[2], hw[3]});
		rel <= 1'b1;
		@(posedge clk);
		rel <= 1'b0;
		repeat (2) @(posedge clk);
		chk(hv, 1'b0);
		clr;
		// Correctable timeout raises the enabled interrupt
		wreg(REG_IRQ_EN, 32'h1);
		wreg(REG_CTRL, 32'h1);
		pul(1'b1, 1'b0);
		rreg(REG_STATUS, 32'h2);
		repeat (10) @(posedge clk);
		chk(st[ERR_TO_COR], 1'b0);
		wst(ERR_TO_COR);
		repeat (4) @(posedge clk);
		chk(lt, MSG_COR);
		chk(irq, 1'b1);
		rreg(REG_IRQ_STAT, 32'h5);
		wreg(REG_IRQ_CLR, 32'h7);
		@(posedge clk);
		chk(irq, 1'b0);
		rreg(REG_IRQ_STAT, 32'h0);
		// Uncorrectable timeout, then masked interrupt
		clr;
		wreg(REG_CTRL, 32'h0);
		pul(1'b1, 1'b0);
		wst(ERR_TO_UNC);
		repeat (4) @(posedge clk);
		chk(lt, MSG_NONFATAL);
		chk(st[ERR_TO_COR], 1'b0);
		wreg(REG_IRQ_EN, 32'h0);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		// Matched completion is quiet, unmatched one is reported
		clr;
		pul(1'b1, 1'b0);
		pul(1'b0, 1'b1);
		repeat (30) @(posedge clk);
		chk(st, 6'h0);
		pul(1'b0, 1'b1);
		wst(ERR_UNEXP);
		// Errors found by the core on its own
		clr;
		@(posedge clk);
		tu <= 1'b1;
		tp <= 1'b1;
		tn <= 1'b1;
		@(posedge clk);
		tu <= 1'b0;
		tp <= 1'b0;
		tn <= 1'b0;
		repeat (3) @(posedge clk);
		chk(st, 6'h38);
		// Three classes strobed together on the second core
		clr;
		n0 = nm2;
		@(posedge clk);
		sb_b.err_strobe <= 7'h25;
		@(posedge clk);
		sb_b.err_strobe <= 7'h0;
		repeat (8) @(posedge clk);
		chk(st2, 6'h25);
		chk(nm2 - n0, 3);
		results;
	end

	// Watchdog
	initial begin
		#100000;
		n_mismatch++;
		results;
	end
endmodule : test_completion_error_report_sideband
